// file: rtl/cal_pkg.sv
// constants, types and helpers for the calendar arithmetic block
// ==========================================================
// Function
// - add operation adds duration, writes result words
// - subtract operation subtracts duration, writes result words
// - calendar words: min/sec, day/hour, year/month
// - error flag set on bad calendar input
// - error flag set on bad duration input
// - zero flag only for zero subtract result
// - adjust loads clock, visible in clock words immediately
// - adjust sets error on out-of-range setting
// - clock word 0: minutes high, seconds low
// - clock word 1: day high, hour low
// - clock word 2: year high, month low
// - clock word 3 low byte: weekday 00..06
// - adjust never checks date exists in calendar
// - clockless variant: adjust errors, fixed clock words
package cal_pkg;

	// ==========================================================
	// register map
	localparam logic [8:0] REG_CAL0     = 9'h000;
	localparam logic [8:0] REG_CAL1     = 9'h001;
	localparam logic [8:0] REG_CAL2     = 9'h002;
	localparam logic [8:0] REG_DUR0     = 9'h003;
	localparam logic [8:0] REG_DUR1     = 9'h004;
	localparam logic [8:0] REG_SET0     = 9'h005;
	localparam logic [8:0] REG_SET1     = 9'h006;
	localparam logic [8:0] REG_SET2     = 9'h007;
	localparam logic [8:0] REG_SET3     = 9'h008;
	localparam logic [8:0] REG_RES0     = 9'h009;
	localparam logic [8:0] REG_RES1     = 9'h00a;
	localparam logic [8:0] REG_RES2     = 9'h00b;
	localparam logic [8:0] REG_CMD      = 9'h00c;
	localparam logic [8:0] REG_FLAGS    = 9'h00d;
	localparam logic [8:0] REG_IRQ_STAT = 9'h00e;
	localparam logic [8:0] REG_IRQ_EN   = 9'h00f;
	localparam logic [8:0] REG_IRQ_CLR  = 9'h010;
	localparam logic [8:0] REG_CLK_MS   = 9'h15f;
	localparam logic [8:0] REG_CLK_DH   = 9'h160;
	localparam logic [8:0] REG_CLK_YM   = 9'h161;
	localparam logic [8:0] REG_CLK_WD   = 9'h162;

	// ==========================================================
	// field positions
	localparam int CMD_ADD  = 0;
	localparam int CMD_SUB  = 1;
	localparam int CMD_ADJ  = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;

	// ==========================================================
	// limits, bcd form
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] SEC_MAX       = 8'h59;
	localparam logic [7:0] HOUR_MAX      = 8'h23;
	localparam logic [7:0] DAY_MAX       = 8'h31;
	localparam logic [7:0] MON_MAX       = 8'h12;
	localparam logic [7:0] YEAR_MAX      = 8'h99;
	localparam logic [7:0] WDAY_MAX      = 8'h06;

	// ==========================================================
	// binary constants
	localparam logic [7:0]  ONE8         = 8'h01;
	localparam logic [7:0]  DEC_RADIX    = 8'h0a;
	localparam logic [7:0]  SEC_PER_MIN  = 8'h3c;
	localparam logic [15:0] HOUR_PER_DAY = 16'h0018;
	localparam logic [15:0] HOUR_CENT    = 16'h0064;
	localparam logic [7:0]  MON_FEB      = 8'h02;
	localparam logic [7:0]  MON_APR      = 8'h04;
	localparam logic [7:0]  MON_JUN      = 8'h06;
	localparam logic [7:0]  MON_SEP      = 8'h09;
	localparam logic [7:0]  MON_NOV      = 8'h0b;
	localparam logic [7:0]  MON_DEC      = 8'h0c;
	localparam logic [7:0]  YEAR_LAST    = 8'h63;
	localparam logic [7:0]  LEAP_CYCLE   = 8'h04;
	localparam logic [7:0]  DAYS_28      = 8'h1c;
	localparam logic [7:0]  DAYS_29      = 8'h1d;
	localparam logic [7:0]  DAYS_30      = 8'h1e;
	localparam logic [7:0]  DAYS_31      = 8'h1f;

	// ==========================================================
	// types
	typedef logic [15:0] word_t;
	typedef logic [2:0][15:0] cal_words_t;
	typedef logic [3:0][15:0] clk_words_t;

	typedef enum logic [1:0] {FSM_IDLE, FSM_ADD, FSM_SUB} fsm_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [8:0] addr;
		word_t      wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} cal_t;

	typedef struct packed {
		fsm_t             fsm;
		logic             busy;
		cal_words_t       cal;
		logic [1:0][15:0] dur;
		clk_words_t       setw;
		cal_words_t       res;
		clk_words_t       clk;
		cal_t             w;
		logic [15:0]      hacc;
		logic [15:0]      hdebt;
		logic             err;
		logic             zero;
		logic [1:0]       ists;
		logic [1:0]       ien;
		logic             irq;
		word_t            rdata;
	} st_t;

	// 01-01-01 01:01:01, sunday
	localparam clk_words_t CLK_DEFAULT = 64'h0000_0101_0101_0101;
	localparam st_t ST_RESET = '{fsm: FSM_IDLE, clk: CLK_DEFAULT, default: '0};

	// ==========================================================
	// helpers
	function automatic logic bcd_ok(input logic [7:0] b, input logic [7:0] mx);
		return (b[3:0] <= BCD_DIGIT_MAX) && (b[7:4] <= BCD_DIGIT_MAX) && (b <= mx);
	endfunction : bcd_ok

	function automatic logic cal_ok(input cal_words_t c);
		return bcd_ok(c[0][7:0], SEC_MAX) && bcd_ok(c[0][15:8], SEC_MAX)
			&& bcd_ok(c[1][7:0], HOUR_MAX) && bcd_ok(c[1][15:8], DAY_MAX)
			&& (c[1][15:8] != '0) && bcd_ok(c[2][7:0], MON_MAX)
			&& (c[2][7:0] != '0) && bcd_ok(c[2][15:8], YEAR_MAX);
	endfunction : cal_ok

	function automatic logic [7:0] b2i(input logic [7:0] b);
		return 8'(b[7:4]) * DEC_RADIX + 8'(b[3:0]);
	endfunction : b2i

	function automatic logic [7:0] i2b(input logic [7:0] v);
		logic [7:0] q;
		q = v / DEC_RADIX;
		return {q[3:0], 4'(v - q * DEC_RADIX)};
	endfunction : i2b

	function automatic logic [7:0] dim(input logic [7:0] m, input logic [7:0] y);
		if (m == MON_FEB) begin
			return ((y % LEAP_CYCLE) == '0) ? DAYS_29 : DAYS_28;
		end
		if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV) begin
			return DAYS_30;
		end
		return DAYS_31;
	endfunction : dim

endpackage : cal_pkg

// file: rtl/calendar_arith_clock_set.sv
// calendar add/subtract engine and clock-adjust register block
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module calendar_arith_clock_set #(
	parameter bit HAS_CLOCK = 1'b1
) (
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire cal_pkg::reg_req_t reg_req_in,
	output var  cal_pkg::word_t    rdata_out,
	output var  logic              irq_out,
	output var  logic              error_flag_out,
	output var  logic              zero_result_flag_out,
	output var  logic              busy_out
);
	import cal_pkg::*;

	// ==========================================================
	// state
	st_t        st_ff;
	st_t        nxt_st;

	logic       cal_good;
	logic       dur_good;
	logic       set_good;
	logic [15:0] dur_hours;

	logic [7:0] c_sec;
	logic [7:0] c_min;
	logic [7:0] c_hour;
	logic [7:0] d_sec;
	logic [7:0] d_min;

	logic [7:0] a_sec_raw;
	logic [7:0] a_min_raw;
	logic       a_sc;
	logic       a_mc;

	logic       s_bs;
	logic       s_bm;
	logic [7:0] s_need;

	cal_t       inc_w;
	cal_t       dec_w;

	// ==========================================================
	// day stepping
	function automatic cal_t day_inc(input cal_t c);
		cal_t r;
		r = c;
		if (c.day >= dim(c.month, c.year)) begin
			r.day = ONE8;
			if (c.month >= MON_DEC) begin
				r.month = ONE8;
				r.year = (c.year >= YEAR_LAST) ? '0 : c.year + ONE8;
			end else begin
				r.month = c.month + ONE8;
			end
		end else begin
			r.day = c.day + ONE8;
		end
		return r;
	endfunction : day_inc

	function automatic cal_t day_dec(input cal_t c);
		cal_t r;
		r = c;
		if (c.day <= ONE8) begin
			if (c.month <= ONE8) begin
				r.month = MON_DEC;
				r.year = (c.year == '0) ? YEAR_LAST : c.year - ONE8;
			end else begin
				r.month = c.month - ONE8;
			end
			r.day = dim(r.month, r.year);
		end else begin
			r.day = c.day - ONE8;
		end
		return r;
	endfunction : day_dec

	// packs fields back into three bcd words
	function automatic cal_words_t pack_cal(input cal_t c);
		return {{i2b(c.year), i2b(c.month)},
			{i2b(c.day), i2b(c.hour)},
			{i2b(c.min), i2b(c.sec)}};
	endfunction : pack_cal

	// ==========================================================
	// operand checks
	assign cal_good = cal_ok(st_ff.cal);
	assign dur_good = bcd_ok(st_ff.dur[0][7:0], SEC_MAX)
		&& bcd_ok(st_ff.dur[0][15:8], SEC_MAX)
		&& bcd_ok(st_ff.dur[1][7:0], YEAR_MAX)
		&& bcd_ok(st_ff.dur[1][15:8], YEAR_MAX);
	// no days-in-month check here
	assign set_good = cal_ok(st_ff.setw[2:0])
		&& bcd_ok(st_ff.setw[3][7:0], WDAY_MAX);

	// ==========================================================
	// start-of-operation arithmetic
	assign c_sec = b2i(st_ff.cal[0][7:0]);
	assign c_min = b2i(st_ff.cal[0][15:8]);
	assign c_hour = b2i(st_ff.cal[1][7:0]);
	assign d_sec = b2i(st_ff.dur[0][7:0]);
	assign d_min = b2i(st_ff.dur[0][15:8]);
	assign dur_hours = 16'(b2i(st_ff.dur[1][15:8])) * HOUR_CENT
		+ 16'(b2i(st_ff.dur[1][7:0]));

	assign a_sec_raw = c_sec + d_sec;
	assign a_sc = a_sec_raw >= SEC_PER_MIN;
	assign a_min_raw = c_min + d_min + 8'(a_sc);
	assign a_mc = a_min_raw >= SEC_PER_MIN;

	assign s_bs = c_sec < d_sec;
	assign s_need = d_min + 8'(s_bs);
	assign s_bm = c_min < s_need;

	assign inc_w = day_inc(st_ff.w);
	assign dec_w = day_dec(st_ff.w);

	// ==========================================================
	// next state
	always_comb begin
		logic [1:0] ev;
		logic [1:0] clr;
		cal_t       fin;
		ev = '0;
		clr = '0;
		fin = st_ff.w;
		nxt_st = st_ff;
		nxt_st.rdata = '0;

		// register reads, data in the next cycle
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				REG_CAL0:     nxt_st.rdata = st_ff.cal[0];
				REG_CAL1:     nxt_st.rdata = st_ff.cal[1];
				REG_CAL2:     nxt_st.rdata = st_ff.cal[2];
				REG_DUR0:     nxt_st.rdata = st_ff.dur[0];
				REG_DUR1:     nxt_st.rdata = st_ff.dur[1];
				REG_SET0:     nxt_st.rdata = st_ff.setw[0];
				REG_SET1:     nxt_st.rdata = st_ff.setw[1];
				REG_SET2:     nxt_st.rdata = st_ff.setw[2];
				REG_SET3:     nxt_st.rdata = st_ff.setw[3];
				REG_RES0:     nxt_st.rdata = st_ff.res[0];
				REG_RES1:     nxt_st.rdata = st_ff.res[1];
				REG_RES2:     nxt_st.rdata = st_ff.res[2];
				REG_FLAGS:    nxt_st.rdata = {13'h0000, st_ff.busy, st_ff.zero, st_ff.err};
				REG_IRQ_STAT: nxt_st.rdata = {14'h0000, st_ff.ists};
				REG_IRQ_EN:   nxt_st.rdata = {14'h0000, st_ff.ien};
				REG_CLK_MS:   nxt_st.rdata = st_ff.clk[0];
				REG_CLK_DH:   nxt_st.rdata = st_ff.clk[1];
				REG_CLK_YM:   nxt_st.rdata = st_ff.clk[2];
				REG_CLK_WD:   nxt_st.rdata = st_ff.clk[3];
				default:      nxt_st.rdata = '0;
			endcase
		end

		// register writes and commands
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				REG_CAL0: nxt_st.cal[0] = reg_req_in.wdata;
				REG_CAL1: nxt_st.cal[1] = reg_req_in.wdata;
				REG_CAL2: nxt_st.cal[2] = reg_req_in.wdata;
				REG_DUR0: nxt_st.dur[0] = reg_req_in.wdata;
				REG_DUR1: nxt_st.dur[1] = reg_req_in.wdata;
				REG_SET0: nxt_st.setw[0] = reg_req_in.wdata;
				REG_SET1: nxt_st.setw[1] = reg_req_in.wdata;
				REG_SET2: nxt_st.setw[2] = reg_req_in.wdata;
				REG_SET3: nxt_st.setw[3] = reg_req_in.wdata;
				REG_IRQ_EN: nxt_st.ien = reg_req_in.wdata[1:0];
				REG_IRQ_CLR: clr = reg_req_in.wdata[1:0];
				REG_CMD: begin
					if (st_ff.fsm == FSM_IDLE) begin
						if (reg_req_in.wdata[CMD_ADD] || reg_req_in.wdata[CMD_SUB]) begin
							nxt_st.zero = 1'b0;
							if (!cal_good || !dur_good) begin
								nxt_st.err = 1'b1;
								ev = 2'h3;
							end else begin
								nxt_st.err = 1'b0;
								nxt_st.w.year = b2i(st_ff.cal[2][15:8]);
								nxt_st.w.month = b2i(st_ff.cal[2][7:0]);
								nxt_st.w.day = b2i(st_ff.cal[1][15:8]);
								nxt_st.w.hour = '0;
								if (reg_req_in.wdata[CMD_ADD]) begin
									nxt_st.fsm = FSM_ADD;
									nxt_st.w.sec = a_sc ? a_sec_raw - SEC_PER_MIN : a_sec_raw;
									nxt_st.w.min = a_mc ? a_min_raw - SEC_PER_MIN : a_min_raw;
									nxt_st.hacc = 16'(c_hour) + dur_hours + 16'(a_mc);
									nxt_st.hdebt = '0;
								end else begin
									nxt_st.fsm = FSM_SUB;
									nxt_st.w.sec = s_bs ? c_sec + SEC_PER_MIN - d_sec : c_sec - d_sec;
									nxt_st.w.min = s_bm ? c_min + SEC_PER_MIN - s_need : c_min - s_need;
									nxt_st.hacc = 16'(c_hour);
									nxt_st.hdebt = dur_hours + 16'(s_bm);
								end
							end
						end else if (reg_req_in.wdata[CMD_ADJ]) begin
							nxt_st.zero = 1'b0;
							if (!HAS_CLOCK || !set_good) begin
								nxt_st.err = 1'b1;
								ev = 2'h3;
							end else begin
								nxt_st.err = 1'b0;
								nxt_st.clk = st_ff.setw;
								ev[IRQ_DONE] = 1'b1;
							end
						end
					end
				end
				default: ;
			endcase
		end

		// day-by-day carry and borrow of whole hours
		case (st_ff.fsm)
			FSM_ADD: begin
				if (st_ff.hacc >= HOUR_PER_DAY) begin
					nxt_st.hacc = st_ff.hacc - HOUR_PER_DAY;
					nxt_st.w = inc_w;
				end else begin
					fin.hour = st_ff.hacc[7:0];
					nxt_st.res = pack_cal(fin);
					nxt_st.zero = 1'b0;
					nxt_st.fsm = FSM_IDLE;
					ev[IRQ_DONE] = 1'b1;
				end
			end
			FSM_SUB: begin
				if (st_ff.hacc >= st_ff.hdebt) begin
					fin.hour = 8'(st_ff.hacc - st_ff.hdebt);
					nxt_st.res = pack_cal(fin);
					nxt_st.zero = (pack_cal(fin) == '0);
					nxt_st.fsm = FSM_IDLE;
					ev[IRQ_DONE] = 1'b1;
				end else begin
					nxt_st.hacc = st_ff.hacc + HOUR_PER_DAY;
					nxt_st.w = dec_w;
				end
			end
			default: ;
		endcase

		// clockless variant keeps fixed clock words
		if (!HAS_CLOCK) begin
			nxt_st.clk = CLK_DEFAULT;
		end

		// sticky status, set wins over clear
		nxt_st.ists = (st_ff.ists & ~clr) | ev;
		nxt_st.irq = |(nxt_st.ists & nxt_st.ien);
		nxt_st.busy = (nxt_st.fsm != FSM_IDLE);
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata_out = st_ff.rdata;
	assign irq_out = st_ff.irq;
	assign error_flag_out = st_ff.err;
	assign zero_result_flag_out = st_ff.zero;
	assign busy_out = st_ff.busy;

	// ==========================================================
	// checks
	localparam int MAX_OP = 500;

	clk_words_t clk_w;
	clk_words_t set_w;
	cal_words_t res_w;
	logic       clk_good;
	logic       sub_run;

	assign clk_w = st_ff.clk;
	assign set_w = st_ff.setw;
	assign res_w = st_ff.res;
	assign clk_good = cal_ok(st_ff.clk[2:0]) && bcd_ok(st_ff.clk[3][7:0], WDAY_MAX);
	assign sub_run = (st_ff.fsm == FSM_SUB);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence cmd_seq;
		reg_req_in.wr && (reg_req_in.addr == REG_CMD) && !busy_out;
	endsequence

	sequence adj_seq;
		cmd_seq ##0 (reg_req_in.wdata[CMD_ADJ] && !reg_req_in.wdata[CMD_ADD]
			&& !reg_req_in.wdata[CMD_SUB]);
	endsequence

	sequence op_seq;
		cmd_seq ##0 (reg_req_in.wdata[CMD_ADD] || reg_req_in.wdata[CMD_SUB]);
	endsequence

	chk_op_bound: assert property ($rose(busy_out) |-> ##[1:MAX_OP] !busy_out)
		else $error("operation did not finish in time");

	chk_res_change: assert property ($changed(res_w) |-> $fell(busy_out))
		else $error("result words changed outside operation end");

	chk_cal_bad: assert property (op_seq ##0 !cal_good |=> error_flag_out && !busy_out)
		else $error("bad calendar did not raise error");

	chk_dur_bad: assert property (op_seq ##0 !dur_good |=> error_flag_out && !busy_out)
		else $error("bad duration did not raise error");

	chk_zero_res: assert property (zero_result_flag_out |-> (res_w == '0) && !busy_out)
		else $error("zero flag with nonzero result");

	chk_add_nozero: assert property (op_seq ##0 reg_req_in.wdata[CMD_ADD] |=> !zero_result_flag_out)
		else $error("zero flag after add");

	chk_adj_load: assert property (adj_seq ##0 (HAS_CLOCK && set_good)
		|=> (clk_w == $past(set_w)) && !error_flag_out)
		else $error("adjust did not load clock");

	chk_adj_error: assert property (adj_seq ##0 !set_good |=> error_flag_out && $stable(clk_w))
		else $error("bad adjust not flagged");

	chk_clock_ranges: assert property (clk_good)
		else $error("clock word field out of range");

	chk_rd_clock: assert property (reg_req_in.rd && (reg_req_in.addr == REG_CLK_MS)
		|=> rdata_out == $past(clk_w[0]))
		else $error("clock word read mismatch");

	chk_no_date_check: assert property (adj_seq ##0 (HAS_CLOCK && set_good && set_w[1][15:8] == DAY_MAX
		&& dim(b2i(set_w[2][7:0]), b2i(set_w[2][15:8])) != DAYS_31) |=> !error_flag_out)
		else $error("nonexistent date raised error");

	chk_clockless: assert property (!HAS_CLOCK |-> (clk_w == CLK_DEFAULT))
		else $error("clockless variant clock words changed");

	chk_clockless_adj: assert property (adj_seq ##0 !HAS_CLOCK |=> error_flag_out)
		else $error("clockless adjust did not error");

	chk_irq_level: assert property (irq_out == |(st_ff.ists & st_ff.ien))
		else $error("interrupt output mismatch");

	chk_op_start: assert property (op_seq ##0 (cal_good && dur_good)
		|=> busy_out && !error_flag_out && !zero_result_flag_out)
		else $error("valid operation did not start");

	chk_sub_zero: assert property ($fell(busy_out) && $past(sub_run)
		|-> zero_result_flag_out == (res_w == '0))
		else $error("zero flag does not match subtract result");

	chk_cmd_refused: assert property (reg_req_in.wr && (reg_req_in.addr == REG_CMD) && busy_out
		|=> $stable(clk_w) && $stable(error_flag_out))
		else $error("command taken while busy");

	chk_rd_weekday: assert property (reg_req_in.rd && (reg_req_in.addr == REG_CLK_WD)
		|=> rdata_out == $past(clk_w[3]))
		else $error("weekday word read mismatch");

	chk_rd_idle: assert property (!reg_req_in.rd
		|=> rdata_out == '0)
		else $error("read data outside read answer cycle");

endmodule : calendar_arith_clock_set

`default_nettype wire

// file: testbench/tb_calendar_arith_clock_set.sv
// self-checking bench for the calendar arithmetic and clock-adjust block
`timescale 1ns/1ps
`default_nettype none

module tb_calendar_arith_clock_set;
	import cal_pkg::*;

	// ==========================================================
	// signals and operand tables
	localparam int    TIMEOUT_CYCLES = 20000;
	localparam word_t BAD_OPS [7][5] = '{
		'{16'h001a, 16'h0100, 16'h2503, 16'h0000, 16'h0000},
		'{16'h0000, 16'h0000, 16'h2503, 16'h0000, 16'h0000},
		'{16'h0000, 16'h0124, 16'h2503, 16'h0000, 16'h0000},
		'{16'h0000, 16'h0100, 16'h2513, 16'h0000, 16'h0000},
		'{16'h6000, 16'h0100, 16'h2503, 16'h0000, 16'h0000},
		'{16'h0000, 16'h0100, 16'h2503, 16'h0060, 16'h0000},
		'{16'h0000, 16'h0100, 16'h2503, 16'h0000, 16'h9a00}
	};
	localparam word_t BAD_SET [6][4] = '{
		'{16'h1530, 16'h3120, 16'h9811, 16'h0007},
		'{16'h1560, 16'h3120, 16'h9811, 16'h0004},
		'{16'h1530, 16'h3200, 16'h9811, 16'h0004},
		'{16'h1530, 16'h3124, 16'h9811, 16'h0004},
		'{16'h1530, 16'h3120, 16'h9800, 16'h0004},
		'{16'h1530, 16'h3120, 16'ha011, 16'h0004}
	};
	localparam word_t NOV31 [4]   = '{16'h1530, 16'h3120, 16'h9811, 16'h0004};
	localparam word_t CLK_DEF [4] = '{16'h0101, 16'h0101, 16'h0101, 16'h0000};

	logic     clk;
	logic     rst;
	reg_req_t req;
	word_t    rdata;
	word_t    rdata2;
	logic     irq;
	logic     irq2;
	logic     err_flag;
	logic     err2;
	logic     zero_flag;
	logic     zero2;
	logic     busy;
	logic     busy2;
	int       err_count;
	int       cmp_count;
	int       cycles = 0;

	// ==========================================================
	// devices: full variant and clockless variant on one bus
	calendar_arith_clock_set #(.HAS_CLOCK(1'b1)) DUT (
		.clk_in               (clk),
		.sys_rst_in           (rst),
		.reg_req_in           (req),
		.rdata_out            (rdata),
		.irq_out              (irq),
		.error_flag_out       (err_flag),
		.zero_result_flag_out (zero_flag),
		.busy_out             (busy)
	);

	calendar_arith_clock_set #(.HAS_CLOCK(1'b0)) dut_basic (
		.clk_in               (clk),
		.sys_rst_in           (rst),
		.reg_req_in           (req),
		.rdata_out            (rdata2),
		.irq_out              (irq2),
		.error_flag_out       (err2),
		.zero_result_flag_out (zero2),
		.busy_out             (busy2)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// compare and bus tasks
	task automatic chk_word(input word_t got, input word_t exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_bit

	task automatic wr_reg(input logic [8:0] addr, input word_t data);
		req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr_reg

	task automatic chk_reg(input logic [8:0] addr, input word_t exp, input word_t exp2);
		req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
		@(posedge clk);
		req <= '0;
		#1;
		chk_word(rdata, exp, "read data");
		chk_word(rdata2, exp2, "read data basic");
		@(posedge clk);
	endtask : chk_reg

	task automatic chk_outs(input logic e, input logic z, input logic e2, input logic i);
		#1;
		chk_bit(err_flag, e, "error flag");
		chk_bit(zero_flag, z, "zero flag");
		chk_bit(err2, e2, "error flag basic");
		chk_bit(irq, i, "irq");
		chk_bit(irq2, i, "irq basic");
		chk_bit(zero2, z, "zero flag basic");
		@(posedge clk);
	endtask : chk_outs

	task automatic run_op(input word_t cmd);
		int n;
		wr_reg(REG_CMD, cmd);
		#1;
		n = 0;
		while (busy === 1'b1 && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_bit(busy, 1'b0, "busy stuck");
		chk_bit(busy2, 1'b0, "busy basic stuck");
		@(posedge clk);
	endtask : run_op

	task automatic set_ops(input word_t w [5]);
		for (int k = 0; k < 5; k++) begin
			wr_reg(REG_CAL0 + 9'(k), w[k]);
		end
	endtask : set_ops

	task automatic set_adj(input word_t w [4]);
		for (int k = 0; k < 4; k++) begin
			wr_reg(REG_SET0 + 9'(k), w[k]);
		end
	endtask : set_adj

	task automatic chk_res(input word_t e [3]);
		for (int k = 0; k < 3; k++) begin
			chk_reg(REG_RES0 + 9'(k), e[k], e[k]);
		end
	endtask : chk_res

	task automatic chk_clk(input word_t e [4]);
		for (int k = 0; k < 4; k++) begin
			chk_reg(REG_CLK_MS + 9'(k), e[k], CLK_DEF[k]);
		end
	endtask : chk_clk

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk_clk(CLK_DEF);
		wr_reg(REG_CLK_MS, 16'hffff);
		chk_reg(REG_CLK_MS, 16'h0101, 16'h0101);
		chk_reg(9'h011, 16'h0000, 16'h0000);
		chk_reg(REG_CMD, 16'h0000, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_add_sub();
		set_ops('{16'h5930, 16'h2823, 16'h2402, 16'h0045, 16'h0001});
		run_op(16'h0001);
		chk_res('{16'h0015, 16'h2901, 16'h2402});
		chk_outs(1'b0, 1'b0, 1'b0, 1'b0);
		set_ops('{16'h0010, 16'h0100, 16'h2503, 16'h0020, 16'h0000});
		run_op(16'h0002);
		chk_res('{16'h5950, 16'h2823, 16'h2502});
		chk_outs(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test add and subtract done");
	endtask : t_add_sub

	task automatic t_bad_ops();
		for (int i = 0; i < 7; i++) begin
			set_ops(BAD_OPS[i]);
			run_op(i[0] ? 16'h0002 : 16'h0001);
			chk_outs(1'b1, 1'b0, 1'b1, 1'b0);
			chk_res('{16'h5950, 16'h2823, 16'h2502});
		end
		$display("test operand errors done");
	endtask : t_bad_ops

	task automatic t_irq();
		wr_reg(REG_IRQ_CLR, 16'h0003);
		chk_reg(REG_IRQ_STAT, 16'h0000, 16'h0000);
		wr_reg(REG_IRQ_EN, 16'h0001);
		chk_reg(REG_IRQ_EN, 16'h0001, 16'h0001);
		set_ops(BAD_OPS[3]);
		run_op(16'h0001);
		chk_reg(REG_IRQ_STAT, 16'h0003, 16'h0003);
		chk_outs(1'b1, 1'b0, 1'b1, 1'b1);
		wr_reg(REG_IRQ_CLR, 16'h0001);
		chk_reg(REG_IRQ_STAT, 16'h0002, 16'h0002);
		chk_outs(1'b1, 1'b0, 1'b1, 1'b0);
		wr_reg(REG_IRQ_EN, 16'h0002);
		chk_outs(1'b1, 1'b0, 1'b1, 1'b1);
		wr_reg(REG_IRQ_CLR, 16'h0002);
		chk_reg(REG_IRQ_STAT, 16'h0000, 16'h0000);
		chk_outs(1'b1, 1'b0, 1'b1, 1'b0);
		wr_reg(REG_IRQ_EN, 16'h0000);
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_adjust();
		set_adj('{16'h1530, 16'h0920, 16'h9810, 16'h0004});
		wr_reg(REG_CMD, 16'h0004);
		chk_clk('{16'h1530, 16'h0920, 16'h9810, 16'h0004});
		chk_outs(1'b0, 1'b0, 1'b1, 1'b0);
		set_adj(NOV31);
		wr_reg(REG_CMD, 16'h0004);
		chk_outs(1'b0, 1'b0, 1'b1, 1'b0);
		chk_clk(NOV31);
		for (int i = 0; i < 6; i++) begin
			set_adj(BAD_SET[i]);
			wr_reg(REG_CMD, 16'h0004);
			chk_outs(1'b1, 1'b0, 1'b1, 1'b0);
		end
		chk_clk(NOV31);
		$display("test clock adjust done");
	endtask : t_adjust

	task automatic t_busy();
		set_adj('{16'h0000, 16'h0101, 16'h0101, 16'h0001});
		set_ops('{16'h0000, 16'h0100, 16'h0001, 16'h0000, 16'h9999});
		wr_reg(REG_CMD, 16'h0001);
		#1;
		chk_bit(busy, 1'b1, "busy");
		@(posedge clk);
		wr_reg(REG_CMD, 16'h0004);
		wr_reg(REG_CAL0, 16'h1111);
		run_op(16'h0002);
		chk_res('{16'h0000, 16'h2015, 16'h0102});
		chk_outs(1'b0, 1'b0, 1'b0, 1'b0);
		chk_clk(NOV31);
		$display("test busy refusal done");
	endtask : t_busy

	// ==========================================================
	// run control
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT_CYCLES) begin
			err_count++;
			$display("mismatch at %0t: run timed out", $time);
			summarize();
		end
	end

	initial begin
		req = '0;
		rst = 1'b1;
		err_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_add_sub();
		t_bad_ops();
		t_irq();
		t_adjust();
		t_busy();
		summarize();
	end

endmodule : tb_calendar_arith_clock_set

`default_nettype wire
